// *** bench/ddw_diag_props.sv ***
module ddw_diag_props
    import ddw_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [15:0] motorVelocity,
    input wire logic        diagVelocityFlag,
    input wire logic        diagWarning,
    input wire logic [7:0]  diagWarningCode,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        aphWr;
    logic [7:0]  aphAddr;
    logic        enSh;
    logic [31:0] velSh;
    logic [1:0]  maskSh;
    int          velNow;
    int          winLo;
    int          winHi;
    wire         taken  = hsel && htrans[1] && hready;
    wire         wrCtrl = aphWr && aphAddr == A_CTRL;
    wire         rdStat = taken && !hwrite && haddr == {24'h0, A_STAT};
    wire         inWin  = velNow >= winLo && velNow <= winHi;
    wire         outWin = velNow < winLo - int'(HYST_RPM) || velNow > winHi + int'(HYST_RPM);
    assign velNow = int'($signed(motorVelocity));
    assign winLo  = int'($signed(velSh[15:0])) - int'(velSh[31:16]);
    assign winHi  = int'($signed(velSh[15:0])) + int'(velSh[31:16]);
    // Shadows follow bus writes so the checker needs no internal probes
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            aphWr <= 1'b0;
        else
            aphWr <= taken && hwrite && haddr[31:8] == 24'h0;
    end
    always_ff @(posedge sys_clk)
    begin
        aphAddr <= haddr[7:0];
    end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enSh   <= 1'b0;
            velSh  <= 32'h0000_0000;
            maskSh <= 2'h0;
        end
        else if (aphWr)
        begin
            enSh   <= (aphAddr == A_CTRL) ? hwdata[EN_BIT] : enSh;
            velSh  <= (aphAddr == A_VEL) ? hwdata : velSh;
            maskSh <= (aphAddr == A_MASK) ? hwdata[1:0] : maskSh;
        end
    end
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    quiet_when_off_a: assert property (
        !enSh [*3] |-> !diagVelocityFlag && !diagWarning && !irq)
        else $error("output active while function disabled");
    vflag_inside_a: assert property (
        enSh && !wrCtrl && inWin |=> diagVelocityFlag)
        else $error("velocity flag low inside window");
    vflag_outside_a: assert property (
        outWin |=> !diagVelocityFlag)
        else $error("velocity flag high beyond hysteresis band");
    vflag_hold_a: assert property (
        enSh && !wrCtrl && !inWin && !outWin |=> $stable(diagVelocityFlag))
        else $error("velocity flag toggled inside hysteresis band");
    warn_sticky_a: assert property (
        diagWarning && enSh && !wrCtrl && !rdStat |=> diagWarning)
        else $error("warning dropped without status read");
    code_match_a: assert property (
        diagWarningCode == (diagWarning ? WARN_CODE : 8'h00))
        else $error("warning code does not match warning");
    irq_masked_a: assert property (
        irq |-> diagWarning && $past(maskSh) != 2'h0)
        else $error("interrupt without masked-in warning");
    unmapped_zero_a: assert property (
        taken && !hwrite && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
        else $error("unmapped read returned data");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    cover property ($rose(diagVelocityFlag));
    cover property ($rose(diagWarning));
    cover property (rdStat && diagWarning);
endmodule

bind ddw_diag ddw_diag_props props_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .motorVelocity(motorVelocity),
    .diagVelocityFlag(diagVelocityFlag), .diagWarning(diagWarning),
    .diagWarningCode(diagWarningCode), .irq(irq)
);

// *** bench/deterioration_diagnosis_warning_tb.sv ***
module deterioration_diagnosis_warning_tb
    import ddw_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // Short tick keeps millisecond counts affordable in simulation
    localparam int TK = 20;
    logic        sysClk = 1'b0;
    logic        rstN = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [15:0] est [4] = '{4{16'h0}};
    logic        estConv = 1'b0;
    logic        estOper = 1'b0;
    logic        rtEst = 1'b0;
    logic [15:0] motorVel = 16'h0;
    logic [15:0] torque = 16'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hreadyout;
    logic        vFlag;
    logic        warn;
    logic        irq;
    int          nFail = 0;
    int          checksDone = 0;
    int          cyc = 0;
    always #2.5 sysClk = ~sysClk;
    ddw_diag #(.TICK_CYC(TK)) dut_u (
        .sys_clk(sysClk), .rst_n(rstN), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .estInertia(est[0]), .estUnbalance(est[1]), .estDynFriction(est[2]),
        .estViscFriction(est[3]), .estConverged(estConv), .estOperating(estOper),
        .rtEstEnable(rtEst), .motorVelocity(motorVel), .torqueCmd(torque),
        .diagVelocityFlag(vFlag), .diagWarning(warn), .diagWarningCode(), .irq(irq)
    );
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge sysClk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            nFail++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            nFail++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge sysClk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge sysClk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sysClk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus({24'h0, a}, 1'b1, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus({24'h0, a}, 1'b0, 32'h0);
        check(rd, exp);
    endtask
    task automatic cyc_wait(input int n);
        repeat (n) @(posedge sysClk);
    endtask
    task automatic t_reset();
        rdc(A_CTRL, CTRL_RST);
        rdc(A_SPEED, {28'h0, SPEED_RST});
        rdc(A_LIM0 + 8'h10, {LIM_MIN, LIM_MAX});
        rdc(A_STAT, 32'h0);
        bus(32'h0000_0100, 1'b1, 32'hFFFF_FFFF);
        bus(32'h0000_0100, 1'b0, 32'h0);
        check(rd, 32'h0);
        rdc(8'hFC, 32'h0);
    endtask
    task automatic t_vflag();
        logic [15:0] vt [6] = '{16'd1050, 16'd1060, 16'd1061, 16'd1051, 16'd950, 16'd939};
        logic        ft [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        wr(A_VEL, 32'h0032_03E8);
        motorVel <= 16'd1000;
        cyc_wait(3);
        check({31'h0, vFlag}, 32'h0);
        wr(A_CTRL, 32'h2);
        cyc_wait(3);
        check({31'h0, vFlag}, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            motorVel <= vt[i];
            cyc_wait(3);
            check({31'h0, vFlag}, {31'h0, ft[i]});
        end
    endtask
    task automatic t_torque();
        wr(A_AVGT, 32'h4);
        wr(A_LIM0 + 8'h10, 32'hFF9C_0064);
        torque <= 16'h00C8;
        motorVel <= 16'd1000;
        cyc_wait(60);
        check({31'h0, warn}, 32'h0);
        cyc_wait(140);
        rdc(A_STATE, 32'h0000_AC06);
        rdc(A_TAVG, 32'h0000_00C8);
        wr(A_MASK, 32'h2);
        cyc_wait(2);
        check({31'h0, irq}, 32'h1);
        wr(A_MASK, 32'h1);
        cyc_wait(2);
        check({31'h0, irq}, 32'h0);
        motorVel <= 16'd0;
        cyc_wait(3);
        rdc(A_STATE, 32'h0000_AC00);
        rdc(A_STAT, 32'h2);
        rdc(A_STAT, 32'h0);
        check({31'h0, warn}, 32'h0);
    endtask
    task automatic t_limits();
        logic [31:0] lt [3] = '{32'h0064_0032, 32'h0064_0064, {LIM_MIN, LIM_MAX}};
        for (int i = 0; i < 3; i++)
        begin
            wr(A_LIM0 + 8'h10, lt[i]);
            motorVel <= 16'd1000;
            cyc_wait(200);
            rdc(A_STAT, 32'h0);
            motorVel <= 16'd0;
            cyc_wait(2);
        end
        wr(A_AVGT, 32'h0);
        motorVel <= 16'd1000;
        cyc_wait(200);
        rdc(A_STATE, 32'h0000_0004);
        motorVel <= 16'd0;
    endtask
    task automatic t_load();
        for (int q = 0; q < 4; q++)
            wr(A_LIM0 + 8'(4 * q), 32'hFE70_0190);
        wr(A_CONV, 32'h3);
        estConv <= 1'b1;
        rtEst <= 1'b1;
        estOper <= 1'b1;
        cyc_wait(30);
        rdc(A_STATE, 32'h0);
        cyc_wait(60);
        rdc(A_STATE, 32'h1);
        for (int q = 0; q < 4; q++)
        begin
            est[q] <= q[0] ? 16'hFE0C : 16'h01F4;
            cyc_wait(3);
            est[q] <= 16'h0;
            cyc_wait(3);
            rdc(A_STAT, 32'h1);
            rdc(A_STAT, 32'h0);
        end
        estConv <= 1'b0;
        cyc_wait(5);
        rdc(A_STATE, 32'h1);
        wr(A_SPEED, 32'h0);
        cyc_wait(90);
        rdc(A_STATE, 32'h0);
        estConv <= 1'b1;
        wr(A_SPEED, 32'h1);
        cyc_wait(90);
        rdc(A_STATE, 32'h1);
        rtEst <= 1'b0;
        cyc_wait(3);
        rdc(A_STATE, 32'h0);
        wr(A_CONV, 32'h0);
        wr(A_SPEED, 32'h3);
        rtEst <= 1'b1;
        cyc_wait(TK * 990);
        rdc(A_STATE, 32'h0);
        cyc_wait(TK * 20);
        rdc(A_STATE, 32'h1);
        wr(A_CTRL, 32'h0);
        cyc_wait(3);
        rdc(A_STATE, 32'h0);
    endtask
    initial
    begin
        repeat (12) @(posedge sysClk);
        rstN <= 1'b1;
        t_reset();
        t_vflag();
        t_torque();
        t_limits();
        t_load();
        tally_and_finish();
    end
endmodule

// *** logic/ddw_diag.sv ***
// Behaviour
// (R1) Whole function runs only with enable bit 1
// (R2) Upper limit at maximum skips upper check
// (R3) Lower limit at minimum skips lower check
// (R4) Upper not above lower disables both checks
// (R5) Load judgment needs accumulated time and convergence
// (R6) Load judgment holds until disable or estimation off
// (R7) Active load judgment flags any breached estimate
// (R8) Estimate limits compared in 0.2 percent steps
// (R9) Zero convergence speed keeps load judgment off
// (R10) Velocity flag set inside set velocity window
// (R11) Velocity flag uses 10 r/min hysteresis
// (R12) Flag on starts averaging; judge after time
// (R13) Flag-to-judgment delay counts inside averaging time
// (R14) Torque judgment drops when velocity flag drops
// (R15) Zero averaging time computes no average
// (R16) Active torque judgment flags breached average
// (R17) Zero convergence time picks time from speed
// (R18) Warning stays sticky until read or disable
//
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
module ddw_diag
    import ddw_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
)(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [15:0] estInertia,
    input  wire logic [15:0] estUnbalance,
    input  wire logic [15:0] estDynFriction,
    input  wire logic [15:0] estViscFriction,
    input  wire logic        estConverged,
    input  wire logic        estOperating,
    input  wire logic        rtEstEnable,
    input  wire logic [15:0] motorVelocity,
    input  wire logic [15:0] torqueCmd,
    output logic             diagVelocityFlag,
    output logic             diagWarning,
    output logic      [7:0]  diagWarningCode,
    output logic             irq
);
    // Settings and status
    logic [31:0] ctrl_reg;
    logic [15:0] convTime_reg;
    logic [3:0]  speed_reg;
    logic [15:0] limUp_reg [NQ];
    logic [15:0] limLo_reg [NQ];
    logic [15:0] setVel_reg;
    logic [15:0] velWidth_reg;
    logic [15:0] avgTime_reg;
    logic [1:0]  mask_reg;
    logic [1:0]  stat_reg;
    // Bus
    logic        wrPend_reg;
    logic [7:0]  wrAddr_reg;
    logic [31:0] hrdata_reg;
    // Block state
    logic [17:0] tick_reg;
    logic [15:0] convMs_reg;
    logic        loadAct_reg;
    logic        vflag_reg;
    ddw_tq_e     tq_reg;
    logic [15:0] tqCnt_reg;
    logic [31:0] tqSum_reg;
    logic [31:0] quo_reg;
    logic [16:0] rem_reg;
    logic [5:0]  step_reg;
    logic        neg_reg;
    logic [16:0] tavg_reg;
    logic        tqAct_reg;
    logic        warn_reg;
    logic [7:0]  code_reg;
    logic        irq_reg;

    wire         en = ctrl_reg[EN_BIT]; // R1
    wire         tick = (tick_reg == 18'(TICK_CYC - 1));

    // AHB-Lite decode; zero wait states, every transfer OKAY
    wire         addrPh = hsel && htrans[1] && hready;
    wire         rdAcc = addrPh && !hwrite;
    wire [7:0]   rdAddr = haddr[7:0];
    wire         rdStat = rdAcc && (haddr[31:8] == 24'h000000) && (rdAddr == A_STAT);
    wire         limW = wrPend_reg && (wrAddr_reg >= A_LIM0) && (wrAddr_reg < A_VEL);
    wire [2:0]   limIdx = 3'((wrAddr_reg - A_LIM0) >> 2);
    wire [2:0]   rdLimIdx = 3'((rdAddr - A_LIM0) >> 2);
    wire         rdLim = (rdAddr >= A_LIM0) && (rdAddr < A_VEL);
    logic [31:0] rdMux;

    always_comb
    begin
        rdMux = 32'h0000_0000;
        if (rdLim && rdAddr[1:0] == 2'b00)
            rdMux = {limLo_reg[rdLimIdx], limUp_reg[rdLimIdx]};
        else
            case (rdAddr)
                A_CTRL:  rdMux = ctrl_reg;
                A_CONV:  rdMux = {16'h0000, convTime_reg};
                A_SPEED: rdMux = {28'h0000000, speed_reg};
                A_VEL:   rdMux = {velWidth_reg, setVel_reg};
                A_AVGT:  rdMux = {16'h0000, avgTime_reg};
                A_STAT:  rdMux = {30'h00000000, stat_reg};
                A_MASK:  rdMux = {30'h00000000, mask_reg};
                A_STATE: rdMux = {16'h0000, code_reg, 5'h00, vflag_reg, tqAct_reg,
                                  loadAct_reg};
                A_TAVG:  rdMux = {{15{tavg_reg[16]}}, tavg_reg};
                default: rdMux = 32'h0000_0000;
            endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
            hrdata_reg <= 32'h0000_0000;
        end
        else
        begin
            wrPend_reg <= addrPh && hwrite && (haddr[31:8] == 24'h000000);
            wrAddr_reg <= rdAddr;
            if (rdAcc)
                hrdata_reg <= (haddr[31:8] == 24'h000000) ? rdMux : 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg     <= CTRL_RST;
            convTime_reg <= 16'h0000;
            speed_reg    <= SPEED_RST;
            setVel_reg   <= 16'h0000;
            velWidth_reg <= 16'h0000;
            avgTime_reg  <= 16'h0000;
            mask_reg     <= 2'b00;
        end
        else if (wrPend_reg)
        begin
            case (wrAddr_reg)
                A_CTRL:  ctrl_reg <= hwdata;
                A_CONV:  convTime_reg <= hwdata[15:0];
                A_SPEED: speed_reg <= hwdata[3:0];
                A_VEL:
                begin
                    setVel_reg   <= hwdata[15:0];
                    velWidth_reg <= hwdata[31:16];
                end
                A_AVGT:  avgTime_reg <= hwdata[15:0];
                A_MASK:  mask_reg <= hwdata[1:0];
                default: ;
            endcase
        end
    end

    // Limit pairs are signed counts of 0.2 percent, same scale as the estimates
    generate
        for (genvar q = 0; q < NQ; q++)
        begin : g_lim
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    limUp_reg[q] <= LIM_MAX;
                    limLo_reg[q] <= LIM_MIN;
                end
                else if (limW && wrAddr_reg[1:0] == 2'b00 && limIdx == 3'(q))
                begin
                    limUp_reg[q] <= hwdata[15:0];
                    limLo_reg[q] <= hwdata[31:16];
                end
            end
        end
    endgenerate

    // Millisecond enable
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            tick_reg <= 18'h00000;
        else
            tick_reg <= tick ? 18'h00000 : tick_reg + 18'h00001;
    end

    // Load-estimate judgment qualification
    logic [15:0] autoMs;
    always_comb
    begin
        case (speed_reg)
            4'h1:    autoMs = AUTO_MS1;
            4'h2:    autoMs = AUTO_MS2;
            default: autoMs = AUTO_MS3;
        endcase
    end
    wire [15:0] convTarget = (convTime_reg == 16'h0000) ? autoMs : convTime_reg; // R17
    wire        loadKill = !en || !rtEstEnable || (speed_reg == 4'h0); // R6 R9
    wire        convDone = (convMs_reg >= convTarget) && estConverged; // R5
    wire        loadAct_next = !loadKill && (loadAct_reg || convDone); // R5 R6

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            convMs_reg  <= 16'h0000;
            loadAct_reg <= 1'b0;
        end
        else
        begin
            loadAct_reg <= loadAct_next;
            // Operating time totals across pauses, so it only restarts on kill
            if (loadKill)
                convMs_reg <= 16'h0000;
            else if (tick && estOperating && convMs_reg != 16'hFFFF)
                convMs_reg <= convMs_reg + 16'h0001; // R5
        end
    end

    // Velocity window with hysteresis
    wire signed [17:0] vel = 18'(signed'(motorVelocity));
    wire signed [17:0] winLo = 18'(signed'(setVel_reg)) - 18'(velWidth_reg);
    wire signed [17:0] winHi = 18'(signed'(setVel_reg)) + 18'(velWidth_reg);
    wire        inWin = (vel >= winLo) && (vel <= winHi); // R10
    wire        outWin = (vel < winLo - signed'(HYST_RPM)) ||
                         (vel > winHi + signed'(HYST_RPM)); // R11
    wire        vflag_next = en && (vflag_reg ? !outWin : inWin); // R1 R10 R11

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            vflag_reg <= 1'b0;
        else
            vflag_reg <= vflag_next;
    end

    // Torque averaging: one ms sample per tick, block average by serial divide
    wire        tqRun = vflag_reg && (avgTime_reg != 16'h0000); // R15
    wire [31:0] sumNext = tqSum_reg + 32'(signed'(torqueCmd));
    wire [31:0] sumMag = sumNext[31] ? 32'(-sumNext) : sumNext;
    wire [16:0] remSh = {rem_reg[15:0], quo_reg[31]};
    wire        remGe = remSh >= {1'b0, avgTime_reg};
    wire        divLast = (step_reg == DIV_STEPS - 6'h01);
    ddw_tq_e    tq_next;

    always_comb
    begin
        tq_next = tq_reg;
        case (tq_reg)
            TQ_OFF:  if (tqRun) tq_next = TQ_ACC; // R12
            TQ_ACC:  if (!tqRun) tq_next = TQ_OFF;
                     else if (tick && tqCnt_reg == avgTime_reg - 16'h0001)
                         tq_next = TQ_DIV; // R13
            TQ_DIV:  if (!tqRun) tq_next = TQ_OFF;
                     else if (divLast) tq_next = TQ_ACC;
            default: tq_next = TQ_OFF;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tq_reg    <= TQ_OFF;
            tqCnt_reg <= 16'h0000;
            tqSum_reg <= 32'h0000_0000;
        end
        else
        begin
            tq_reg <= tq_next;
            if (tq_reg != TQ_ACC || tq_next != TQ_ACC)
            begin
                tqCnt_reg <= 16'h0000;
                tqSum_reg <= (tq_next == TQ_DIV) ? tqSum_reg + 32'(signed'(torqueCmd))
                                                 : 32'h0000_0000;
            end
            else if (tick)
            begin
                tqCnt_reg <= tqCnt_reg + 16'h0001;
                tqSum_reg <= tqSum_reg + 32'(signed'(torqueCmd)); // R12
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            quo_reg  <= 32'h0000_0000;
            rem_reg  <= 17'h00000;
            step_reg <= 6'h00;
            neg_reg  <= 1'b0;
        end
        else if (tq_reg == TQ_ACC && tq_next == TQ_DIV)
        begin
            quo_reg  <= sumMag;
            rem_reg  <= 17'h00000;
            step_reg <= 6'h00;
            neg_reg  <= sumNext[31];
        end
        else if (tq_reg == TQ_DIV)
        begin
            rem_reg  <= remGe ? remSh - {1'b0, avgTime_reg} : remSh;
            quo_reg  <= {quo_reg[30:0], remGe};
            step_reg <= step_reg + 6'h01;
        end
    end

    // Sum and divide see the last sample, so the window equals the set time
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tavg_reg  <= 17'h00000;
            tqAct_reg <= 1'b0;
        end
        else
        begin
            if (tq_reg == TQ_DIV && divLast && tqRun)
                tavg_reg <= neg_reg ? 17'(-{1'b0, quo_reg[14:0], remGe})
                                    : {1'b0, quo_reg[14:0], remGe};
            if (!tqRun)
                tqAct_reg <= 1'b0; // R14
            else if (tq_reg == TQ_DIV && divLast)
                tqAct_reg <= 1'b1; // R12 R13
        end
    end

    // Limit comparisons, one per monitored quantity
    logic signed [16:0] qVal [NQ];
    logic [NQ-1:0]      exceed;
    assign qVal[0] = 17'(signed'(estInertia)); // R8
    assign qVal[1] = 17'(signed'(estUnbalance));
    assign qVal[2] = 17'(signed'(estDynFriction));
    assign qVal[3] = 17'(signed'(estViscFriction));
    assign qVal[TQ_IDX] = signed'(tavg_reg);
    generate
        for (genvar q = 0; q < NQ; q++)
        begin : g_cmp
            wire signed [16:0] up = 17'(signed'(limUp_reg[q]));
            wire signed [16:0] lo = 17'(signed'(limLo_reg[q]));
            wire pairOk = up > lo; // R4
            wire upEn = pairOk && (limUp_reg[q] != LIM_MAX); // R2
            wire loEn = pairOk && (limLo_reg[q] != LIM_MIN); // R3
            assign exceed[q] = (upEn && qVal[q] > up) || (loEn && qVal[q] < lo);
        end
    endgenerate

    wire        loadEvt = loadAct_reg && (|exceed[3:0]); // R7
    wire        torqEvt = tqAct_reg && exceed[TQ_IDX]; // R16
    logic [1:0] evt;
    logic [1:0] stat_next;
    assign evt[ST_LOAD] = loadEvt;
    assign evt[ST_TORQ] = torqEvt;
    // Reading clears, but an event in the same cycle survives the read
    assign stat_next = en ? ((rdStat ? 2'b00 : stat_reg) | evt) : 2'b00; // R18 R1

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stat_reg <= 2'b00;
            warn_reg <= 1'b0;
            code_reg <= 8'h00;
            irq_reg  <= 1'b0;
        end
        else
        begin
            stat_reg <= stat_next; // R18
            warn_reg <= |stat_next;
            code_reg <= (|stat_next) ? WARN_CODE : 8'h00; // R7 R16
            irq_reg  <= |(stat_next & mask_reg);
        end
    end

    assign hrdata           = hrdata_reg;
    assign hreadyout        = 1'b1;
    assign hresp            = 1'b0;
    assign diagVelocityFlag = vflag_reg;
    assign diagWarning      = warn_reg;
    assign diagWarningCode  = code_reg;
    assign irq              = irq_reg;
endmodule

// *** logic/ddw_pkg.sv ***
package ddw_pkg;
    // Register byte offsets
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_CONV  = 8'h04;
    localparam logic [7:0] A_SPEED = 8'h08;
    localparam logic [7:0] A_LIM0  = 8'h0C;
    localparam logic [7:0] A_VEL   = 8'h20;
    localparam logic [7:0] A_AVGT  = 8'h24;
    localparam logic [7:0] A_STAT  = 8'h28;
    localparam logic [7:0] A_MASK  = 8'h2C;
    localparam logic [7:0] A_STATE = 8'h30;
    localparam logic [7:0] A_TAVG  = 8'h34;
    localparam int         NQ      = 5;
    localparam int         TQ_IDX  = 4;
    // Field positions
    localparam int         EN_BIT   = 1;
    localparam int         ST_LOAD  = 0;
    localparam int         ST_TORQ  = 1;
    localparam int         SS_LOAD  = 0;
    localparam int         SS_TORQ  = 1;
    localparam int         SS_VFLAG = 2;
    localparam int         SS_CODE  = 8;
    // Reset values; limits reset to the values that disable them
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [15:0] LIM_MAX   = 16'h7FFF;
    localparam logic [15:0] LIM_MIN   = 16'h8000;
    localparam logic [3:0]  SPEED_RST = 4'h1;
    localparam logic [7:0]  WARN_CODE = 8'hAC;
    // Timing
    localparam int          CLK_NS      = 5;
    localparam int          TICK_NS     = 1000000;
    localparam int          TICK_CYCLES = TICK_NS / CLK_NS;
    localparam logic [17:0] HYST_RPM    = 18'h0000A;
    localparam logic [15:0] AUTO_MS1    = 16'h0FA0;
    localparam logic [15:0] AUTO_MS2    = 16'h07D0;
    localparam logic [15:0] AUTO_MS3    = 16'h03E8;
    localparam logic [5:0]  DIV_STEPS   = 6'h20;
    typedef enum logic [2:0] {
        TQ_OFF = 3'b001,
        TQ_ACC = 3'b010,
        TQ_DIV = 3'b100
    } ddw_tq_e;
endpackage
